// >>> hw/iccc_top.sv
// i2c control channel configuration: settings, watchdog, address remap
//
// What this block does
// - SDA output changes 240/280/320/360 ns after SCL falls, chosen by bus settings bits 4:3.
// - with the local write block bit set, register writes arriving over the link are dropped.
// - link accesses to other serializer-side targets pass on whatever the block bit says.
// - the bus watchdog expires after about 50 ms with speedup set and about 1 s without.
// - the watchdog-disable bit stops the bus watchdog.
// - SDA high with no bus activity for about 1 s marks the bus as free.
// - SDA low with no activity at watchdog expiry starts nine SCL clock pulses.
// - the remote deserializer address sits in bits 7:1 of its register, reset 0x00.
// - a zero deserializer address stops forwarding to the deserializer.
// - on receiver lock the deserializer address is loaded from the link unless frozen or written in that same cycle.
// - with the freeze bit set the software-written deserializer address is kept.
// - the remote target physical address sits in bits 7:1 of its register, reset 0x00.
// - a local access to the remote target alias is sent on with the physical address.
// - a zero remote target alias blocks access to the remote target.
`timescale 1ns/10ps
module iccc_top
  import iccc_pkg::*;
#(
  parameter logic [6:0]      SELF_ADDR   = 7'h0C,
  parameter logic [WD_W-1:0] WD_FAST_CYC = WD_W'(WD_FAST_MS * 1000 * CLK_MHZ),
  parameter logic [WD_W-1:0] WD_SLOW_CYC = WD_W'(WD_SLOW_MS * 1000 * CLK_MHZ)
) (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  // i2c pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            scl_o,
  output logic            scl_oen_o,
  output logic            sda_o,
  output logic            sda_oen_o,
  input  wire logic       sda_low_req_i,
  // local register port
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // local master forwarding
  input  wire logic       mst_req_i,
  input  wire logic [6:0] mst_addr_i,
  input  wire logic [6:0] remote_target_alias_i,
  output logic            fwd_req_o,
  output logic      [6:0] fwd_addr_o,
  output logic            fwd_drop_o,
  // watchdog status
  output logic            bus_free_o,
  output logic            bus_rcv_o,
  // link side
  input  wire logic       lclk_i,
  input  wire logic       rx_lock_i,
  input  wire logic [6:0] rx_des_addr_i,
  input  wire logic       lnk_req_i,
  input  wire logic [6:0] lnk_addr_i,
  input  wire logic [7:0] lnk_reg_i,
  input  wire logic [7:0] lnk_data_i,
  input  wire logic       lnk_wr_i,
  output logic            lnk_busy_o,
  // link accesses to serializer-side targets
  output logic            lcl_pass_o,
  output logic      [6:0] lcl_pass_addr_o,
  output logic      [7:0] lcl_pass_reg_o,
  output logic      [7:0] lcl_pass_data_o,
  output logic            lcl_pass_wr_o,
  output logic            rmt_wr_blocked_o
);
  // ==========================================================
  // link domain
  logic [1:0] lrst_q;
  logic       lrstn;
  logic       lreq_tg_q, lack_s1_q, lack_s2_q, lock_q, lid_tg_q;
  logic [6:0] lid_q, laddr_q;
  logic [7:0] lreg_q, ldata_q;
  logic       lwr_q;
  logic       mack_tg_q;

  always_ff @(posedge lclk_i) lrst_q <= {lrst_q[0], rstn_i};
  assign lrstn = lrst_q[1];

  always_ff @(posedge lclk_i) begin
    lack_s1_q <= mack_tg_q;
    lack_s2_q <= lack_s1_q;
  end

  always_ff @(posedge lclk_i) begin
    if (!lrstn) begin
      lreq_tg_q  <= 1'b0;
      lnk_busy_o <= 1'b0;
      laddr_q    <= 7'h00;
      lreg_q     <= 8'h00;
      ldata_q    <= 8'h00;
      lwr_q      <= 1'b0;
    end else if (lnk_req_i && !lnk_busy_o) begin
      lreq_tg_q  <= ~lreq_tg_q;
      lnk_busy_o <= 1'b1;
      laddr_q    <= lnk_addr_i;
      lreg_q     <= lnk_reg_i;
      ldata_q    <= lnk_data_i;
      lwr_q      <= lnk_wr_i;
    end else if (lnk_busy_o && (lack_s2_q == lreq_tg_q)) begin
      lnk_busy_o <= 1'b0;
    end
  end

  // capture the address sent by the deserializer at lock
  always_ff @(posedge lclk_i) begin
    if (!lrstn) begin
      lock_q   <= 1'b0;
      lid_tg_q <= 1'b0;
      lid_q    <= 7'h00;
    end else begin
      lock_q <= rx_lock_i;
      if (rx_lock_i && !lock_q) begin
        lid_q    <= rx_des_addr_i;
        lid_tg_q <= ~lid_tg_q;
      end
    end
  end

  // ==========================================================
  // crossings into mclk
  logic [2:0] mreq_s_q, mlid_s_q;
  logic [1:0] scl_s_q, sda_s_q;
  logic       scl_d_q, sda_d_q;
  logic       rmt_seen, lid_seen, scl_fall, act;

  always_ff @(posedge mclk_i) begin
    mreq_s_q <= {mreq_s_q[1:0], lreq_tg_q};
    mlid_s_q <= {mlid_s_q[1:0], lid_tg_q};
    scl_s_q  <= {scl_s_q[0], scl_i};
    sda_s_q  <= {sda_s_q[0], sda_i};
    scl_d_q  <= scl_s_q[1];
    sda_d_q  <= sda_s_q[1];
  end
  assign rmt_seen = mreq_s_q[2] ^ mreq_s_q[1];
  assign lid_seen = mlid_s_q[2] ^ mlid_s_q[1];
  assign scl_fall = scl_d_q && !scl_s_q[1];
  assign act      = (scl_d_q ^ scl_s_q[1]) | (sda_d_q ^ sda_s_q[1]);

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) mack_tg_q <= 1'b0;
    else if (rmt_seen) mack_tg_q <= ~mack_tg_q;
  end

  // ==========================================================
  // registers
  logic [7:0] bus_set_q, des_q, tgt_q;
  logic       rmt_self, rmt_wr_ok, wr_en;
  logic [7:0] wr_addr, wr_data;

  assign rmt_self  = rmt_seen && (laddr_q == SELF_ADDR);
  assign rmt_wr_ok = rmt_self && lwr_q && !bus_set_q[BIT_LCL_WR_BLK] && !reg_wr_i;
  assign wr_en     = reg_wr_i | rmt_wr_ok;
  assign wr_addr   = reg_wr_i ? reg_addr_i : lreg_q;
  assign wr_data   = reg_wr_i ? reg_wdata_i : ldata_q;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      bus_set_q <= RST_BUS_SETTINGS;
      des_q     <= RST_DES_ADDR;
      tgt_q     <= RST_TGT_PHYS;
    end else begin
      if (wr_en && wr_addr == OFS_BUS_SETTINGS) bus_set_q <= wr_data & MSK_BUS_SETTINGS;
      if (wr_en && wr_addr == OFS_TGT_PHYS) tgt_q <= wr_data & MSK_TGT_PHYS;
      if (wr_en && wr_addr == OFS_DES_ADDR) des_q <= wr_data & MSK_DES_ADDR;
      else if (lid_seen && !des_q[BIT_FREEZE]) des_q[7:BIT_ADDR_LO] <= lid_q;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) reg_rdata_o <= 8'h00;
    else if (reg_rd_i) begin
      unique case (reg_addr_i)
        OFS_BUS_SETTINGS: reg_rdata_o <= bus_set_q;
        OFS_DES_ADDR:     reg_rdata_o <= des_q;
        OFS_TGT_PHYS:     reg_rdata_o <= tgt_q;
        default:          reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // link requests: own registers or pass to local targets
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      lcl_pass_o       <= 1'b0;
      lcl_pass_addr_o  <= 7'h00;
      lcl_pass_reg_o   <= 8'h00;
      lcl_pass_data_o  <= 8'h00;
      lcl_pass_wr_o    <= 1'b0;
      rmt_wr_blocked_o <= 1'b0;
    end else begin
      lcl_pass_o       <= rmt_seen && !rmt_self;
      rmt_wr_blocked_o <= rmt_self && lwr_q && bus_set_q[BIT_LCL_WR_BLK];
      if (rmt_seen && !rmt_self) begin
        lcl_pass_addr_o <= laddr_q;
        lcl_pass_reg_o  <= lreg_q;
        lcl_pass_data_o <= ldata_q;
        lcl_pass_wr_o   <= lwr_q;
      end
    end
  end

  // ==========================================================
  // forwarding and remap
  logic [6:0] des_addr, tgt_addr;
  logic       hit_des, hit_tgt;
  assign des_addr = des_q[7:BIT_ADDR_LO];
  assign tgt_addr = tgt_q[7:BIT_ADDR_LO];
  assign hit_des  = (des_addr != 7'h00) && (mst_addr_i == des_addr);
  assign hit_tgt  = (remote_target_alias_i != 7'h00) && (mst_addr_i == remote_target_alias_i);

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      fwd_req_o  <= 1'b0;
      fwd_drop_o <= 1'b0;
      fwd_addr_o <= 7'h00;
    end else begin
      fwd_req_o  <= mst_req_i && (hit_des || hit_tgt);
      fwd_drop_o <= mst_req_i && !hit_des && !hit_tgt;
      if (mst_req_i && hit_des) fwd_addr_o <= des_addr;
      else if (mst_req_i && hit_tgt) fwd_addr_o <= tgt_addr;
    end
  end

  // ==========================================================
  // sda output delay
  logic [7:0] dly_cnt_q;
  logic       dly_run_q, dly_fire;
  assign dly_fire = dly_run_q && (dly_cnt_q == 8'h00);

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      dly_run_q <= 1'b0;
      dly_cnt_q <= 8'h00;
      sda_o     <= 1'b0;
      sda_oen_o <= 1'b1;
    end else begin
      if (scl_fall) begin
        dly_run_q <= 1'b1;
        dly_cnt_q <= SDA_DLY_BASE_CYC - 8'h01 +
                     SDA_DLY_STEP_CYC * 8'(bus_set_q[BIT_DLY_LO+1:BIT_DLY_LO]);
      end else if (dly_fire) dly_run_q <= 1'b0;
      else if (dly_run_q) dly_cnt_q <= dly_cnt_q - 8'h01;
      if (dly_fire) sda_oen_o <= !sda_low_req_i;
    end
  end

  // ==========================================================
  // bus watchdog
  iccc_wd_e            wd_q;
  logic [WD_W-1:0]     wd_cnt_q, wd_lim;
  logic [11:0]         half_q;
  logic [4:0]          pls_q;
  logic                wd_dis;
  assign wd_dis = bus_set_q[BIT_WD_DISABLE];
  assign wd_lim = bus_set_q[BIT_WD_SPEEDUP] ? WD_FAST_CYC : WD_SLOW_CYC;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      wd_q       <= WD_WATCH;
      wd_cnt_q   <= '0;
      half_q     <= 12'h000;
      pls_q      <= 5'h00;
      scl_o      <= 1'b0;
      scl_oen_o  <= 1'b1;
      bus_free_o <= 1'b0;
      bus_rcv_o  <= 1'b0;
    end else begin
      unique case (wd_q)
        WD_WATCH: begin
          if (wd_dis || act) wd_cnt_q <= '0;
          else if (wd_cnt_q != WD_SLOW_CYC) wd_cnt_q <= wd_cnt_q + WD_W'(1);
          if (act) bus_free_o <= 1'b0;
          else if (!wd_dis && sda_s_q[1] && wd_cnt_q == WD_SLOW_CYC - 1'b1)
            bus_free_o <= 1'b1;
          if (!wd_dis && !act && !sda_s_q[1] && wd_cnt_q == wd_lim - 1'b1) begin
            wd_q      <= WD_RECOVER;
            bus_rcv_o <= 1'b1;
            scl_oen_o <= 1'b0;
            half_q    <= RCV_HALF_CYC;
            pls_q     <= 5'h00;
          end
        end
        WD_RECOVER: begin
          wd_cnt_q <= '0;
          if (half_q != 12'h000) half_q <= half_q - 12'h001;
          else if (!scl_oen_o) begin
            scl_oen_o <= 1'b1;
            pls_q     <= pls_q + 5'h01;
            half_q    <= RCV_HALF_CYC;
          end else if (pls_q == RCV_PULSES) begin
            wd_q      <= WD_WATCH;
            bus_rcv_o <= 1'b0;
          end else begin
            scl_oen_o <= 1'b0;
            half_q    <= RCV_HALF_CYC;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // assertions
  sequence dly3_start_s;
    scl_fall && bus_set_q[BIT_DLY_LO+1:BIT_DLY_LO] == 2'h3;
  endsequence
  sda_delay_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    dly3_start_s ##1 (!scl_fall)[*8] |-> ##64 dly_fire)
    else $error("sda delay not 360 ns");
  wr_block_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    rmt_self && lwr_q && bus_set_q[BIT_LCL_WR_BLK] && !reg_wr_i && !lid_seen
      |=> $stable(bus_set_q) && $stable(tgt_q) && $stable(des_q) && rmt_wr_blocked_o)
    else $error("blocked link write changed a register");
  pass_through_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    rmt_seen && !rmt_self |=> lcl_pass_o && lcl_pass_addr_o == $past(laddr_q))
    else $error("link access to local target not passed on");
  wd_expire_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    wd_q == WD_WATCH && !wd_dis && !act && !sda_s_q[1] && wd_cnt_q == wd_lim - 1'b1
      |=> bus_rcv_o && !scl_oen_o)
    else $error("watchdog did not start recovery at expiry");
  wd_stop_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    wd_dis && wd_q == WD_WATCH |=> wd_cnt_q == '0 && !$rose(bus_rcv_o))
    else $error("disabled watchdog still counting");
  bus_free_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $rose(bus_free_o) |-> $past(sda_s_q[1]) && $past(wd_cnt_q) == WD_SLOW_CYC - 1'b1)
    else $error("bus marked free without 1 s of idle high sda");
  nine_pulses_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $fell(bus_rcv_o) |-> pls_q == RCV_PULSES && scl_oen_o)
    else $error("recovery ended without nine pulses");
  des_zero_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    mst_req_i && des_addr == 7'h00 && !hit_tgt |=> !fwd_req_o && fwd_drop_o)
    else $error("access forwarded with zero deserializer address");
  autoload_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    lid_seen && !des_q[BIT_FREEZE] && !(wr_en && wr_addr == OFS_DES_ADDR)
      |=> des_q[7:BIT_ADDR_LO] == $past(lid_q))
    else $error("deserializer address not loaded at lock");
  freeze_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    des_q[BIT_FREEZE] && !(wr_en && wr_addr == OFS_DES_ADDR) |=> $stable(des_q))
    else $error("frozen deserializer address changed");
  remap_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    mst_req_i && hit_tgt && !hit_des |=> fwd_req_o && fwd_addr_o == $past(tgt_addr))
    else $error("alias access not remapped");
  alias_zero_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    mst_req_i && remote_target_alias_i == 7'h00 && !hit_des |=> !fwd_req_o)
    else $error("access forwarded with zero alias");
endmodule

// >>> hw/iccc_pkg.sv
// constants for the i2c control channel configuration block
package iccc_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_BUS_SETTINGS = 8'h05;
  localparam logic [7:0] OFS_DES_ADDR     = 8'h06;
  localparam logic [7:0] OFS_TGT_PHYS     = 8'h07;
  // ==========================================================
  // reset values and writable masks
  localparam logic [7:0] RST_BUS_SETTINGS = 8'h00;
  localparam logic [7:0] RST_DES_ADDR     = 8'h00;
  localparam logic [7:0] RST_TGT_PHYS     = 8'h00;
  localparam logic [7:0] MSK_BUS_SETTINGS = 8'h1F;
  localparam logic [7:0] MSK_DES_ADDR     = 8'hFF;
  localparam logic [7:0] MSK_TGT_PHYS     = 8'hFE;
  // ==========================================================
  // field positions
  localparam int BIT_WD_DISABLE = 0;
  localparam int BIT_WD_SPEEDUP = 1;
  localparam int BIT_LCL_WR_BLK = 2;
  localparam int BIT_DLY_LO     = 3;
  localparam int BIT_FREEZE     = 0;
  localparam int BIT_ADDR_LO    = 1;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS  = 5;
  localparam int CLK_MHZ        = 200;
  localparam int SDA_DLY_BASE_NS = 240;
  localparam int SDA_DLY_STEP_NS = 40;
  localparam logic [7:0] SDA_DLY_BASE_CYC = 8'(SDA_DLY_BASE_NS / CLK_PERIOD_NS);
  localparam logic [7:0] SDA_DLY_STEP_CYC = 8'(SDA_DLY_STEP_NS / CLK_PERIOD_NS);
  localparam int WD_FAST_MS     = 50;
  localparam int WD_SLOW_MS     = 1000;
  localparam int RCV_HALF_NS    = 5000;
  localparam logic [11:0] RCV_HALF_CYC = 12'(RCV_HALF_NS / CLK_PERIOD_NS);
  localparam logic [4:0]  RCV_PULSES   = 5'h09;
  localparam int WD_W           = 28;
  // ==========================================================
  // watchdog states
  typedef enum logic [0:0] {WD_WATCH, WD_RECOVER} iccc_wd_e;
endpackage

// >>> tb/iccc_link_model.sv
// link-side partner: deserializer end of the control channel
`timescale 1ns/10ps
module iccc_link_model (
  // link clock and request state
  input  wire logic       lclk_i,
  input  wire logic       busy_i,
  // lock and address delivery
  output logic            rx_lock_o,
  output logic      [6:0] rx_des_addr_o,
  // link requests
  output logic            lnk_req_o,
  output logic      [6:0] lnk_addr_o,
  output logic      [7:0] lnk_reg_o,
  output logic      [7:0] lnk_data_o,
  output logic            lnk_wr_o
);
  initial begin
    {rx_lock_o, rx_des_addr_o, lnk_req_o, lnk_addr_o, lnk_reg_o, lnk_data_o, lnk_wr_o} = '0;
  end

  // ==========================================================
  // lock change with the address that the link reports
  task automatic lock(input logic on, input logic [6:0] a);
    @(posedge lclk_i);
    #1;
    rx_des_addr_o = a;
    rx_lock_o     = on;
    repeat (4) @(posedge lclk_i);
    #1;
    rx_des_addr_o = ~a;
  endtask

  // ==========================================================
  // one request, sent once busy is low, held for one link clock, fields scrambled after
  task automatic send(input logic [6:0] a, input logic [7:0] r, d, input logic w);
    int n;
    @(posedge lclk_i);
    for (n = 0; n < 40 && busy_i !== 1'b0; n++) @(posedge lclk_i);
    #1;
    {lnk_addr_o, lnk_reg_o, lnk_data_o, lnk_wr_o} = {a, r, d, w};
    lnk_req_o = 1'b1;
    @(posedge lclk_i);
    #1;
    lnk_req_o = 1'b0;
    {lnk_addr_o, lnk_reg_o, lnk_data_o, lnk_wr_o} = ~{a, r, d, w};
    for (n = 0; n < 40 && busy_i !== 1'b0; n++) @(posedge lclk_i);
  endtask
endmodule

// >>> tb/tb.sv
// self-checking bench for the i2c control channel configuration block
`timescale 1ns/10ps
module tb;
  import iccc_pkg::*;
  // ==========================================================
  // signals
  localparam logic [6:0]      SELF = 7'h0C;
  localparam logic [WD_W-1:0] WD_F = 28'h00000C8;
  localparam logic [WD_W-1:0] WD_S = 28'h0000190;
  typedef struct packed {logic [7:0] a, d, e;} iccc_row_s;
  iccc_row_s  rows [6] = '{'{8'h05, 8'hFF, 8'h1F}, '{8'h05, 8'hE4, 8'h04},
    '{8'h06, 8'hA5, 8'hA5}, '{8'h07, 8'hFF, 8'hFE}, '{8'h07, 8'h01, 8'h00},
    '{8'h08, 8'hFF, 8'h00}};
  logic       mclk_i = 1'b0, lclk_i = 1'b0, rstn_i = 1'b0, q;
  logic       scl_drv = 1'b1, sda_drv = 1'b1, sda_low_req_i = 1'b0;
  logic       reg_wr_i = 1'b0, reg_rd_i = 1'b0, mst_req_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, v;
  logic [6:0] mst_addr_i = 7'h00, remote_target_alias_i = 7'h00;
  logic       scl_o, scl_oen_o, sda_o, sda_oen_o, fwd_req_o, fwd_drop_o, bus_free_o;
  logic       bus_rcv_o, lnk_busy_o, lcl_pass_o, lcl_pass_wr_o, rmt_wr_blocked_o;
  logic       rx_lock_i, lnk_req_i, lnk_wr_i;
  logic [6:0] rx_des_addr_i, lnk_addr_i, fwd_addr_o, lcl_pass_addr_o;
  logic [7:0] reg_rdata_o, lnk_reg_i, lnk_data_i, lcl_pass_reg_o, lcl_pass_data_o;
  wire logic  scl_i = scl_drv & scl_oen_o;
  wire logic  sda_i = sda_drv & sda_oen_o;
  int         errors = 0, checks = 0, n_pass = 0, n_blk = 0, n, p;

  always #2.5 mclk_i = ~mclk_i;
  always #15 lclk_i = ~lclk_i;

  iccc_top #(.SELF_ADDR(SELF), .WD_FAST_CYC(WD_F), .WD_SLOW_CYC(WD_S)) u_iccc_top (
    .mclk_i, .rstn_i, .scl_i, .sda_i, .scl_o, .scl_oen_o, .sda_o, .sda_oen_o,
    .sda_low_req_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
    .mst_req_i, .mst_addr_i, .remote_target_alias_i, .fwd_req_o, .fwd_addr_o,
    .fwd_drop_o, .bus_free_o, .bus_rcv_o, .lclk_i, .rx_lock_i, .rx_des_addr_i,
    .lnk_req_i, .lnk_addr_i, .lnk_reg_i, .lnk_data_i, .lnk_wr_i, .lnk_busy_o,
    .lcl_pass_o, .lcl_pass_addr_o, .lcl_pass_reg_o, .lcl_pass_data_o, .lcl_pass_wr_o,
    .rmt_wr_blocked_o);

  iccc_link_model u_link (
    .lclk_i, .busy_i(lnk_busy_o), .rx_lock_o(rx_lock_i), .rx_des_addr_o(rx_des_addr_i),
    .lnk_req_o(lnk_req_i), .lnk_addr_o(lnk_addr_i), .lnk_reg_o(lnk_reg_i),
    .lnk_data_o(lnk_data_i), .lnk_wr_o(lnk_wr_i));

  always @(posedge mclk_i) begin
    if (lcl_pass_o === 1'b1) n_pass++;
    if (rmt_wr_blocked_o === 1'b1) n_blk++;
  end

  // ==========================================================
  // tasks
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, d);
    {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
    cyc(1);
    reg_wr_i = 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    {reg_addr_i, reg_rd_i} = {a, 1'b1};
    cyc(1);
    reg_rd_i = 1'b0;
    cyc(1);
    d = reg_rdata_o;
  endtask

  task automatic fwd(input logic [6:0] a, input logic go, input logic [6:0] ea);
    {mst_addr_i, mst_req_i} = {a, 1'b1};
    cyc(1);
    mst_req_i = 1'b0;
    chk("fwd", {fwd_req_o, fwd_drop_o}, {go, ~go});
    if (go) chk("fwd_addr", fwd_addr_o, ea);
    cyc(1);
  endtask

  task automatic close_out();
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #400000;
    errors++;
    close_out();
  end

  // ==========================================================
  // sequence
  initial begin
    cyc(30);
    rstn_i = 1'b1;
    cyc(4);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk("reg", v, rows[i].e);
    end
    rstn_i = 1'b0;
    cyc(30);
    chk("oen", {scl_o, sda_o, scl_oen_o, sda_oen_o}, 4'h3);
    rstn_i = 1'b1;
    cyc(4);
    for (int i = 5; i < 8; i++) begin
      rd(8'(i), v);
      chk("rst", v, 8'h00);
    end
    fwd(7'h00, 1'b0, 7'h00);
    wr(OFS_DES_ADDR, 8'h41);
    fwd(7'h20, 1'b1, 7'h20);
    wr(OFS_TGT_PHYS, 8'h66);
    remote_target_alias_i = 7'h11;
    fwd(7'h11, 1'b1, 7'h33);
    fwd(7'h55, 1'b0, 7'h00);
    remote_target_alias_i = 7'h00;
    fwd(7'h00, 1'b0, 7'h00);
    u_link.send(SELF, OFS_TGT_PHYS, 8'h44, 1'b1);
    cyc(10);
    rd(OFS_TGT_PHYS, v);
    chk("lnk_wr", v, 8'h44);
    wr(OFS_BUS_SETTINGS, 8'h04);
    u_link.send(SELF, OFS_TGT_PHYS, 8'h88, 1'b1);
    cyc(10);
    rd(OFS_TGT_PHYS, v);
    chk("lnk_blk", {v, 4'(n_blk)}, {8'h44, 4'h1});
    u_link.send(7'h50, 8'h12, 8'h34, 1'b1);
    cyc(10);
    chk("pass", {4'(n_pass), lcl_pass_addr_o, lcl_pass_reg_o, lcl_pass_data_o,
      lcl_pass_wr_o}, {4'h1, 7'h50, 8'h12, 8'h34, 1'b1});
    u_link.send(7'h51, 8'h9A, 8'hBC, 1'b0);
    cyc(10);
    chk("pass_rd", {4'(n_pass), lcl_pass_addr_o, lcl_pass_wr_o}, {4'h2, 7'h51, 1'b0});
    chk("busy", lnk_busy_o, 1'b0);
    wr(OFS_DES_ADDR, 8'h00);
    u_link.lock(1'b1, 7'h2A);
    cyc(20);
    rd(OFS_DES_ADDR, v);
    chk("load", v, 8'h54);
    u_link.lock(1'b0, 7'h00);
    wr(OFS_DES_ADDR, 8'h27);
    u_link.lock(1'b1, 7'h2B);
    cyc(20);
    rd(OFS_DES_ADDR, v);
    chk("frz", v, 8'h27);
    for (int c = 0; c < 4; c++) begin
      wr(OFS_BUS_SETTINGS, 8'(c * 8 + 1));
      sda_low_req_i = 1'b1;
      scl_drv = 1'b0;
      for (n = 0; n < 200 && sda_oen_o !== 1'b0; n++) cyc(1);
      p = SDA_DLY_BASE_CYC + c * SDA_DLY_STEP_CYC + 1;
      chk("dly", 1'(n >= p && n <= p + 4), 1'b1);
      sda_low_req_i = 1'b0;
      scl_drv = 1'b1;
      cyc(4);
      scl_drv = 1'b0;
      cyc(120);
      scl_drv = 1'b1;
      cyc(4);
    end
    wr(OFS_BUS_SETTINGS, 8'h00);
    scl_drv = 1'b0;
    cyc(2);
    scl_drv = 1'b1;
    cyc(300);
    chk("free0", bus_free_o, 1'b0);
    cyc(150);
    chk("free1", bus_free_o, 1'b1);
    for (int s = 0; s < 2; s++) begin
      wr(OFS_BUS_SETTINGS, 8'(s * 2));
      sda_drv = 1'b0;
      for (n = 0; n < 1000 && bus_rcv_o !== 1'b1; n++) cyc(1);
      p = s ? WD_F : WD_S;
      chk("wd", 1'(n >= p && n <= p + 8), 1'b1);
      p = 0;
      q = 1'b1;
      for (n = 0; n < 30000 && bus_rcv_o === 1'b1; n++) begin
        cyc(1);
        if (scl_oen_o === 1'b0 && q === 1'b1) p++;
        q = scl_oen_o;
      end
      chk("pulses", p, 9);
      chk("rcv_end", bus_rcv_o, 1'b0);
      sda_drv = 1'b1;
      cyc(5);
    end
    wr(OFS_BUS_SETTINGS, 8'h03);
    sda_drv = 1'b0;
    cyc(600);
    chk("wdoff", bus_rcv_o, 1'b0);
    sda_drv = 1'b1;
    close_out();
  end
endmodule
